// ### stepper_pkg.sv
// Constants and types shared by the stepper phase sequencer
package stepper_pkg;
   typedef logic [7:0] pos_t;
   typedef enum logic [1:0] {
      MICRO = 2'b00,
      HALF = 2'b01,
      HALF_FT = 2'b10,
      FULL = 2'b11
   } mode_t;
   typedef enum logic [1:0] {
      CH_FORCED = 2'b00,
      CH_CHARGE = 2'b01,
      CH_SLOW = 2'b10,
      CH_FAST = 2'b11
   } chop_t;
   // Bus slave address, value is arbitrary
   localparam logic [6:0] SLAVE_ADDR = 7'h32;
   localparam logic [1:0] REG_PAIR_A = 2'h0;
   localparam logic [1:0] REG_PAIR_B = 2'h1;
   localparam logic [1:0] REG_STEP = 2'h2;
   localparam logic [1:0] REG_MISC = 2'h3;
   localparam int B_OE = 7;
   localparam int B_RUN = 6;
   localparam int B_HOLD = 5;
   localparam int B_DIR = 4;
   localparam int B_CHOP = 0;
   localparam int B_PHOTO = 2;
   localparam int B_FLAG_PAIR = 3;
   localparam int B_FLAG_HALF = 4;
   localparam logic [7:0] CFG_PAIR_RST = 8'h40;
   localparam logic [7:0] CFG_STEP_RST = 8'h00;
   localparam logic [7:0] CFG_MISC_RST = 8'h00;
   localparam pos_t POS_INIT = 8'h00;
   localparam pos_t POS_INIT_FULL = 8'hE0;
   localparam logic [5:0] QUAD_MID = 6'h20;
   localparam int CLK_KHZ = 10000;
   localparam int CHOP0_KHZ = 400;
   localparam int CHOP1_KHZ = 200;
   localparam int CHOP2_KHZ = 600;
   localparam int CHOP3_KHZ = 300;
   localparam logic [3:0][5:0] CHOP_CYC = {
      6'(CLK_KHZ / CHOP3_KHZ), 6'(CLK_KHZ / CHOP2_KHZ),
      6'(CLK_KHZ / CHOP1_KHZ), 6'(CLK_KHZ / CHOP0_KHZ)};
   localparam int FORCED_NS = 500;
   localparam logic [5:0] FORCED_CYC =
      6'((FORCED_NS * CLK_KHZ + 999_999) / 1_000_000);
endpackage

// ### stepper_pair.sv
// Position counter of one channel pair: divider, hold, mode switch
`timescale 1ns/100ps
module stepper_pair (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Control
   input wire logic i_enable,
   input wire logic i_run,
   input wire logic i_hold,
   input wire logic i_reverse,
   input wire logic [1:0] i_div,
   input wire stepper_pkg::mode_t i_mode,
   input wire logic i_step_clk,
   // Position
   output stepper_pkg::pos_t o_pos,
   output logic o_at_init
);
   import stepper_pkg::*;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   logic hold_q;
   logic hold_lvl;
   logic clk_int;
   logic clk_int_q;
   logic rise;
   logic step;
   logic [2:0] div_cnt;
   logic [2:0] div_last;
   mode_t last_mode;
   pos_t init_pos;
   pos_t mag;
   pos_t next_pos;

   assign init_pos = (i_mode == FULL) ? POS_INIT_FULL : POS_INIT;

   // Catch the step clock level when hold is first seen
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         hold_q <= 1'b0;
         hold_lvl <= 1'b0;
      end else begin
         hold_q <= i_hold;
         if (i_hold && !hold_q) begin
            hold_lvl <= i_step_clk;
         end
      end
   end

   // Held level replaces the pin, so no edge reaches the divider
   assign clk_int = (i_hold && hold_q) ? hold_lvl : i_step_clk;
   assign rise = clk_int && !clk_int_q;
   assign div_last = 3'((4'h1 << i_div) - 4'h1);
   assign step = rise && (div_cnt >= div_last) && i_enable && i_run;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         clk_int_q <= 1'b0;
      end else begin
         clk_int_q <= clk_int;
      end
   end

   // Divider; >= lets a smaller ratio take over at the next edge
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || !i_enable || !i_run) begin
         div_cnt <= 3'h0;
      end else if (rise) begin
         if (div_cnt >= div_last) begin
            div_cnt <= 3'h0;
         end else begin
            div_cnt <= div_cnt + 3'h1;
         end
      end
   end

   // Next position, with the snap after a mode change
   always_comb begin
      unique case (i_mode)
         MICRO: mag = 8'h01;
         HALF, HALF_FT: mag = 8'h20;
         FULL: mag = 8'h40;
      endcase
      // Forward counts up: second channel lags the first
      next_pos = i_reverse ? o_pos - mag : o_pos + mag;
      if (i_mode != last_mode) begin
         unique case (i_mode)
            MICRO: begin
            end
            HALF, HALF_FT: begin
               if (o_pos[5:0] != QUAD_MID) begin
                  next_pos = {o_pos[7:6], QUAD_MID};
               end
            end
            FULL: next_pos = {o_pos[7:6], QUAD_MID};
         endcase
      end
   end

   // Standby and counter reset pin the position; steps advance it
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_pos <= POS_INIT;
         last_mode <= MICRO;
      end else if (!i_enable || !i_run) begin
         o_pos <= init_pos;
         last_mode <= i_mode;
      end else if (step) begin
         o_pos <= next_pos;
         last_mode <= i_mode;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_at_init <= 1'b1;
      end else begin
         o_at_init <= (o_pos == init_pos);
      end
   end

   a_hold_freeze: assert property (
      i_hold && hold_q && i_enable && i_run |=> $stable(o_pos))
      else $error("position moved during hold");
   a_reset_init: assert property (
      !i_enable || !i_run |=> o_pos == $past(init_pos))
      else $error("position not at initial while held");
   a_fwd_micro: assert property (
      step && !i_reverse && i_mode == MICRO && last_mode == MICRO
      |=> o_pos == pos_t'($past(o_pos) + 8'h01))
      else $error("forward micro step wrong");
   a_rev_micro: assert property (
      step && i_reverse && i_mode == MICRO && last_mode == MICRO
      |=> o_pos == pos_t'($past(o_pos) - 8'h01))
      else $error("reverse micro step wrong");
   a_full_snap: assert property (
      step && i_mode == FULL && last_mode != FULL
      |=> o_pos[5:0] == QUAD_MID)
      else $error("full step snap missed");
   a_half_snap: assert property (
      step && i_mode == HALF && last_mode != HALF
      && o_pos[5:0] != QUAD_MID |=> o_pos[5:0] == QUAD_MID)
      else $error("half step snap missed");
   a_half_next: assert property (
      step && i_mode == HALF && last_mode != HALF && !i_reverse
      && o_pos[5:0] == QUAD_MID
      |=> o_pos == pos_t'($past(o_pos) + 8'h20))
      else $error("half step from mid point wrong");
   c_mode_switch: cover property (step && i_mode != last_mode);
   c_hold_step: cover property (i_hold ##1 !i_hold ##[1:4] step);
endmodule

// ### stepper_phase_sequencer.sv
// Two-pair stepping core: serial slave, settings, pairs, choppers
`timescale 1ns/100ps
module stepper_phase_sequencer (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Serial bus, open drain data
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   // Motor pins
   input wire logic i_standby_release_pin,
   input wire logic i_step_clk_a,
   input wire logic i_step_clk_b,
   input wire logic i_rotation_direction_pin_a,
   input wire logic i_rotation_direction_pin_b,
   input wire logic i_below_target_a,
   input wire logic i_below_target_b,
   // Phase positions and drive enables
   output stepper_pkg::pos_t o_pos_a,
   output stepper_pkg::pos_t o_pos_b,
   output logic o_drive_on_a,
   output logic o_drive_on_b,
   // Current control
   output logic [3:0] o_target_current_level_a,
   output logic [3:0] o_target_current_level_b,
   output logic [1:0] o_chop_sel,
   output stepper_pkg::chop_t o_chop_phase_a,
   output stepper_pkg::chop_t o_chop_phase_b,
   // Miscellaneous
   output logic o_photo_on,
   output logic o_position_flag_output_n
);
   import stepper_pkg::*;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   typedef enum logic [1:0] {
      I2C_IDLE = 2'b00,
      I2C_BYTE = 2'b01,
      I2C_ACK = 2'b10
   } i2c_t;

   logic [8:0] pin_meta;
   logic [8:0] pin_s;
   logic scl_s;
   logic sda_s;
   logic ena_s;
   logic [1:0] step_s;
   logic [1:0] dir_s;
   logic [1:0] below_s;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   i2c_t state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] wbyte;
   logic [1:0] byte_idx;
   logic [1:0] reg_ptr;
   logic ack_ok;
   logic last_bit;
   logic commit;
   logic [3:0][7:0] cfg;
   pos_t [1:0] pos;
   logic [1:0] at_init;
   logic [1:0] drive;
   chop_t [1:0] chop;
   logic [5:0] period;
   logic [5:0] slow_end;
   logic flag_pair;
   logic flag_low;

   // Every pin is asynchronous to the core clock; bus lines reset high
   // to match their idle level, so no false edge follows reset
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         pin_meta <= 9'h003;
         pin_s <= 9'h003;
      end else begin
         pin_meta <= {i_below_target_b, i_below_target_a,
            i_rotation_direction_pin_b, i_rotation_direction_pin_a,
            i_step_clk_b, i_step_clk_a, i_standby_release_pin,
            i_sda, i_scl};
         pin_s <= pin_meta;
      end
   end

   assign scl_s = pin_s[0];
   assign sda_s = pin_s[1];
   assign ena_s = pin_s[2];
   assign step_s = pin_s[4:3];
   assign dir_s = pin_s[6:5];
   assign below_s = pin_s[8:7];

   // Previous bus levels for edge, start and stop detection
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_q;
   assign scl_fall = !scl_s && scl_q;
   assign start = scl_s && scl_q && sda_q && !sda_s;
   assign stop = scl_s && scl_q && !sda_q && sda_s;
   assign wbyte = {shift[6:0], sda_s};
   assign last_bit = (state == I2C_BYTE) && scl_rise && (bit_cnt == 4'h7);
   // Data bytes commit on the eighth clock rise, not on the ack
   assign commit = last_bit && (byte_idx == 2'h2);

   // Write-only slave: address, register pointer, data bytes
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= I2C_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         byte_idx <= 2'h0;
         reg_ptr <= REG_PAIR_A;
         ack_ok <= 1'b0;
         o_sda_oe_n <= 1'b1;
      end else if (start) begin
         state <= I2C_BYTE;
         bit_cnt <= 4'h0;
         byte_idx <= 2'h0;
         o_sda_oe_n <= 1'b1;
      end else if (stop) begin
         state <= I2C_IDLE;
         o_sda_oe_n <= 1'b1;
      end else begin
         unique case (state)
            I2C_IDLE: begin
            end
            I2C_BYTE: begin
               if (scl_rise && bit_cnt < 4'h8) begin
                  shift <= wbyte;
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == 4'h7) begin
                     unique case (byte_idx)
                        2'h0: ack_ok <= (wbyte[7:1] == SLAVE_ADDR)
                           && !wbyte[0];
                        2'h1: begin
                           reg_ptr <= wbyte[1:0];
                           ack_ok <= (wbyte[7:2] == 6'h00);
                        end
                        default: reg_ptr <= reg_ptr + 2'h1;
                     endcase
                  end
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  if (ack_ok) begin
                     state <= I2C_ACK;
                     o_sda_oe_n <= 1'b0;
                  end else begin
                     // Reads and foreign addresses are left alone
                     state <= I2C_IDLE;
                  end
               end
            end
            I2C_ACK: begin
               if (scl_fall) begin
                  o_sda_oe_n <= 1'b1;
                  state <= I2C_BYTE;
                  bit_cnt <= 4'h0;
                  if (byte_idx != 2'h2) begin
                     byte_idx <= byte_idx + 2'h1;
                  end
               end
            end
            default: state <= I2C_IDLE;
         endcase
      end
   end

   // Open drain: only ever pulls low
   always_ff @(posedge i_ref_clk) begin
      o_sda <= 1'b0;
   end

   // Settings, accepted even in standby
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cfg[REG_PAIR_A] <= CFG_PAIR_RST;
         cfg[REG_PAIR_B] <= CFG_PAIR_RST;
         cfg[REG_STEP] <= CFG_STEP_RST;
         cfg[REG_MISC] <= CFG_MISC_RST;
      end else if (commit) begin
         cfg[reg_ptr] <= wbyte;
      end
   end

   // One sequencer, drive enable and chopper per channel pair
   for (genvar g = 0; g < 2; g++) begin : g_pair
      logic [5:0] cnt;
      logic seen;
      logic reverse;

      // Pin high wins; pin low defers to the serial setting
      assign reverse = dir_s[g] || cfg[g][B_DIR];

      stepper_pair u_pair (
         .i_ref_clk(i_ref_clk),
         .i_rst(i_rst),
         .i_enable(ena_s),
         .i_run(cfg[g][B_RUN]),
         .i_hold(cfg[g][B_HOLD]),
         .i_reverse(reverse),
         .i_div(cfg[REG_STEP][2*g +: 2]),
         .i_mode(mode_t'(cfg[REG_STEP][4+2*g +: 2])),
         .i_step_clk(step_s[g]),
         .o_pos(pos[g]),
         .o_at_init(at_init[g])
      );

      // Position keeps counting underneath an output disabled by B_OE; standby pins it
      always_ff @(posedge i_ref_clk) begin
         if (i_rst) begin
            drive[g] <= 1'b0;
         end else begin
            drive[g] <= ena_s && cfg[g][B_OE];
         end
      end

      // Chopper; a shorter new period ends the current one at once
      always_ff @(posedge i_ref_clk) begin
         if (i_rst) begin
            chop[g] <= CH_FORCED;
            cnt <= 6'h00;
            seen <= 1'b0;
         end else if (cnt >= period - 6'h01) begin
            cnt <= 6'h00;
            chop[g] <= CH_FORCED;
            seen <= 1'b0;
         end else begin
            cnt <= cnt + 6'h01;
            unique case (chop[g])
               CH_FORCED: begin
                  seen <= seen || below_s[g];
                  if (cnt == FORCED_CYC - 6'h01) begin
                     chop[g] <= (seen || below_s[g]) ?
                        CH_CHARGE : CH_FAST;
                  end
               end
               CH_CHARGE: begin
                  if (!below_s[g]) begin
                     chop[g] <= CH_SLOW;
                  end
               end
               CH_SLOW: begin
                  if (cnt >= slow_end) begin
                     chop[g] <= CH_FAST;
                  end
               end
               CH_FAST: begin
               end
            endcase
         end
      end
   end

   // Slow decay gives way to fast decay for the last quarter
   assign period = CHOP_CYC[cfg[REG_MISC][B_CHOP +: 2]];
   assign slow_end = period - (period >> 2);

   // Position flag: initial point, or half-step points in micro mode
   assign flag_pair = cfg[REG_MISC][B_FLAG_PAIR];
   assign flag_low = at_init[flag_pair] || (cfg[REG_MISC][B_FLAG_HALF]
      && cfg[REG_STEP][4+2*flag_pair +: 2] == MICRO
      && pos[flag_pair][4:0] == 5'h00);

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_position_flag_output_n <= 1'b1;
         o_photo_on <= 1'b0;
      end else begin
         o_position_flag_output_n <= !flag_low;
         o_photo_on <= cfg[REG_MISC][B_PHOTO];
      end
   end

   // Outputs taken straight from registers
   assign o_pos_a = pos[0];
   assign o_pos_b = pos[1];
   assign o_drive_on_a = drive[0];
   assign o_drive_on_b = drive[1];
   // Higher code means lower reference voltage
   assign o_target_current_level_a = cfg[REG_PAIR_A][3:0];
   assign o_target_current_level_b = cfg[REG_PAIR_B][3:0];
   assign o_chop_sel = cfg[REG_MISC][B_CHOP +: 2];
   assign o_chop_phase_a = chop[0];
   assign o_chop_phase_b = chop[1];

   a_standby_hiz: assert property (
      !ena_s |=> !o_drive_on_a && !o_drive_on_b)
      else $error("drive on during standby");
   a_drive_on: assert property (
      commit && reg_ptr == REG_PAIR_A && wbyte[B_OE] && ena_s
      ##1 ena_s |=> o_drive_on_a)
      else $error("output enable not applied");
   a_commit_store: assert property (
      commit && reg_ptr == REG_PAIR_B
      |=> o_target_current_level_b == $past(wbyte[3:0]))
      else $error("current code not committed");
   a_chop_wrap: assert property (
      g_pair[0].cnt >= period - 6'h01
      |=> o_chop_phase_a == CH_FORCED)
      else $error("period did not restart in forced charge");
   a_chop_fast: assert property (
      o_chop_phase_a == CH_FORCED && !g_pair[0].seen && !below_s[0]
      && g_pair[0].cnt == FORCED_CYC - 6'h01
      && g_pair[0].cnt < period - 6'h01
      |=> o_chop_phase_a == CH_FAST)
      else $error("fast decay not entered");
   c_commit: cover property (commit);
   c_charge: cover property (o_chop_phase_a == CH_CHARGE ##[1:40]
      o_chop_phase_a == CH_SLOW);
   c_drive: cover property (o_drive_on_a && o_drive_on_b);
endmodule

// ### i2c_step_host.sv
// Host model: serial bus writer and step clock source for pair A
`timescale 1ns/100ps
module i2c_step_host (
   // Clock and bus wire
   input wire logic i_ref_clk,
   input wire logic i_sda,
   // Driven lines
   output logic o_scl,
   output logic o_sda,
   output logic o_step_clk
);
   import stepper_pkg::*;

   // Bus clock stands still high between frames
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
      o_step_clk = 1'b0;
   end

   // Move just after a rising edge, never on it
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #10;
   endtask

   // MSB first; half periods of 10 clocks clear the 8 the slave needs
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         o_sda = b[i];
         tick(5);
         o_scl = 1'b1;
         tick(10);
         o_scl = 1'b0;
         tick(5);
      end
      o_sda = 1'b1;
      tick(5);
      o_scl = 1'b1;
      tick(5);
      ack = ~i_sda;
      tick(5);
      o_scl = 1'b0;
      tick(5);
   endtask

   // Start, address, register byte, one data byte, stop
   task automatic write_reg(input logic [7:0] r, input logic [7:0] d,
         output logic ok);
      logic a0, a1, a2;
      o_sda = 1'b0;
      tick(10);
      o_scl = 1'b0;
      tick(5);
      put_byte({SLAVE_ADDR, 1'b0}, a0);
      put_byte(r, a1);
      put_byte(d, a2);
      o_sda = 1'b0;
      tick(5);
      o_scl = 1'b1;
      tick(5);
      o_sda = 1'b1;
      tick(10);
      ok = a0 & a1 & a2;
   endtask

   // Four clocks high and low, then room for the position to land
   task automatic step(input int n);
      repeat (n) begin
         o_step_clk = 1'b1;
         tick(4);
         o_step_clk = 1'b0;
         tick(4);
      end
      tick(2);
   endtask
endmodule

// ### tb.sv
// Self-checking testbench of the stepper phase sequencer
`timescale 1ns/100ps
module tb;
   import stepper_pkg::*;
   logic i_ref_clk, i_rst, i_standby_release_pin, i_below_target_a;
   logic i_rotation_direction_pin_a, scl, host_sda, sda, step_a;
   logic o_sda, o_sda_oe_n, o_drive_on_a, o_drive_on_b, o_photo_on, flag_n;
   logic [3:0] o_target_current_level_a, o_target_current_level_b;
   logic [1:0] o_chop_sel;
   pos_t o_pos_a, o_pos_b;
   chop_t o_chop_phase_a, o_chop_phase_b;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;

   // Pull-up wire: either party may only pull low
   assign sda = host_sda & (o_sda_oe_n | o_sda);

   stepper_phase_sequencer uut (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
      .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
      .i_standby_release_pin(i_standby_release_pin),
      .i_step_clk_a(step_a), .i_step_clk_b(1'b0),
      .i_rotation_direction_pin_a(i_rotation_direction_pin_a),
      .i_rotation_direction_pin_b(1'b0),
      .i_below_target_a(i_below_target_a), .i_below_target_b(1'b0),
      .o_pos_a(o_pos_a), .o_pos_b(o_pos_b), .o_drive_on_a(o_drive_on_a),
      .o_drive_on_b(o_drive_on_b),
      .o_target_current_level_a(o_target_current_level_a),
      .o_target_current_level_b(o_target_current_level_b),
      .o_chop_sel(o_chop_sel), .o_chop_phase_a(o_chop_phase_a),
      .o_chop_phase_b(o_chop_phase_b), .o_photo_on(o_photo_on),
      .o_position_flag_output_n(flag_n)
   );

   i2c_step_host host (
      .i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl),
      .o_sda(host_sda), .o_step_clk(step_a)
   );

   // 10 MHz clock
   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   // Hang guard, well above the roughly 22000 cycles the run needs
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic print_verdict;
      if (n_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check_val(input logic [7:0] got, exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, exp, input string m);
      check_val({7'h00, got}, {7'h00, exp}, m);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #10;
   endtask

   task automatic wr(input logic [7:0] r, d);
      logic ok;
      host.write_reg(r, d, ok);
      check_bit(ok, 1'b1, "ack");
   endtask

   task automatic step_chk(input int n, input pos_t exp);
      host.step(n);
      check_val(o_pos_a, exp, "pos");
   endtask

   // Bounded wait for a chopper phase on pair A
   task automatic wait_phase(input chop_t exp);
      int n;
      n = 0;
      while (o_chop_phase_a !== exp && n < 100) begin
         tick(1);
         n++;
      end
      check_val({6'h00, o_chop_phase_a}, {6'h00, exp}, "phase");
   endtask

   // Standby blocks steps and drive, yet settings are accepted
   task automatic t_standby;
      host.step(2);
      check_val(o_pos_a, POS_INIT, "sby pos");
      wr(8'h00, 8'hC5);
      check_bit(o_drive_on_a, 1'b0, "sby drv");
      check_val({4'h0, o_target_current_level_a}, 8'h05, "lvl");
      i_standby_release_pin = 1'b1;
      tick(6);
      check_bit(o_drive_on_a, 1'b1, "run drv");
      step_chk(1, 8'h01);
   endtask

   // Pin high forces reverse; low hands back to the register bit
   task automatic t_dir;
      i_rotation_direction_pin_a = 1'b1;
      tick(4);
      step_chk(1, 8'h00);
      i_rotation_direction_pin_a = 1'b0;
      tick(4);
      step_chk(1, 8'h01);
   endtask

   task automatic t_oe;
      wr(8'h00, 8'h45);
      check_bit(o_drive_on_a, 1'b0, "oe off");
      step_chk(2, 8'h03);
      wr(8'h00, 8'hC5);
      check_bit(o_drive_on_a, 1'b1, "oe on");
   endtask

   // Hold latched with the step pin low, so release brings no extra step
   task automatic t_hold;
      wr(8'h00, 8'hE5);
      step_chk(2, 8'h03);
      wr(8'h00, 8'hC5);
      step_chk(1, 8'h04);
   endtask

   task automatic t_creset;
      wr(8'h00, 8'h85);
      check_val(o_pos_a, POS_INIT, "clr");
      step_chk(1, POS_INIT);
      wr(8'h00, 8'hC5);
      step_chk(1, 8'h01);
   endtask

   // Whole groups of 2^d pulses make one step, each ratio starting from divider phase zero
   task automatic t_div;
      pos_t p;
      p = 8'h01;
      for (int d = 1; d < 4; d++) begin
         wr(8'h02, 8'(d));
         p = p + 8'h01;
         step_chk(1 << d, p);
      end
   endtask

   task automatic t_mode;
      wr(8'h02, 8'h10);
      check_val(o_pos_a, 8'h04, "wait");
      step_chk(1, 8'h20);
      step_chk(1, 8'h40);
      wr(8'h02, 8'h20);
      step_chk(1, 8'h60);
      wr(8'h02, 8'h10);
      step_chk(1, 8'h80);
      wr(8'h02, 8'h30);
      step_chk(1, 8'hA0);
      step_chk(1, 8'hE0);
   endtask

   task automatic t_serdir;
      wr(8'h00, 8'hD5);
      check_val(o_pos_a, 8'hE0, "dir wait");
      step_chk(1, 8'hA0);
      wr(8'h00, 8'hC5);
      step_chk(1, 8'hE0);
   endtask

   // Every current code on pair B, then an unmapped register
   task automatic t_levels;
      logic ok;
      for (int c = 0; c < 16; c++) begin
         wr(8'h01, 8'h40 | 8'(c));
         check_val({4'h0, o_target_current_level_b}, 8'(c), "lvl");
      end
      check_val(o_pos_b, POS_INIT, "pos b");
      check_bit(o_drive_on_b, 1'b0, "drv b");
      host.write_reg(8'h04, 8'h00, ok);
      check_bit(ok, 1'b0, "bad reg");
   endtask

   // Ends on the 400 kHz code so periods stay short
   task automatic t_chop;
      int n;
      for (int s = 3; s >= 0; s--) begin
         wr(8'h03, 8'(s));
         check_val({6'h00, o_chop_sel}, 8'(s), "chop");
      end
      i_below_target_a = 1'b1;
      wait_phase(CH_FORCED);
      wait_phase(CH_CHARGE);
      i_below_target_a = 1'b0;
      wait_phase(CH_SLOW);
      wait_phase(CH_FAST);
      wait_phase(CH_FORCED);
      check_val({6'h00, o_chop_phase_b}, {6'h00, CH_FORCED}, "ph b");
      n = 0;
      repeat (60) begin
         tick(1);
         if (o_chop_phase_a === CH_SLOW) n++;
      end
      check_val(8'(n), 8'h00, "slow");
   endtask

   task automatic t_sleep;
      wr(8'h03, 8'h04);
      check_bit(o_photo_on, 1'b1, "photo");
      i_standby_release_pin = 1'b0;
      tick(6);
      check_bit(o_drive_on_a, 1'b0, "slp drv");
      check_val(o_pos_a, POS_INIT_FULL, "slp pos");
      check_bit(flag_n, 1'b0, "flag init");
      i_standby_release_pin = 1'b1;
      tick(6);
      check_bit(o_drive_on_a, 1'b1, "wake");
      step_chk(1, 8'h20);
      check_bit(flag_n, 1'b1, "flag off");
   endtask

   // Reset for 16 cycles, then the scenarios in order
   initial begin
      i_rst = 1'b1;
      i_standby_release_pin = 1'b0;
      i_rotation_direction_pin_a = 1'b0;
      i_below_target_a = 1'b0;
      tick(16);
      i_rst = 1'b0;
      tick(2);
      t_standby();
      t_dir();
      t_oe();
      t_hold();
      t_creset();
      t_div();
      t_mode();
      t_serdir();
      t_levels();
      t_chop();
      t_sleep();
      print_verdict();
   end
endmodule
